// *** dv/hbd_ctl_tb.sv ***
`timescale 1ns/10ps
`include "hbd_defs.svh"
module hbd_ctl_tb;
   import hbd_pkg::*;
   logic core_clk = '0;
   logic rstn = '0;
   logic wb_cyc = '0, wb_stb = '0, wb_we = '0, wb_ack;
   logic [7:0] wb_adr = '0;
   logic [3:0] wb_sel = 4'hf;
   logic [31:0] wb_dat_i = '0, wb_dat_o, q;
   logic cpu_req = '0, cpu_we = '0, cpu_wc = '0, cpu_smm = '0;
   logic cpu_ready, cpu_defer, cpu_rvalid, pci_mready, pci_rvalid;
   logic pci_mreq = '0, pci_mwe = '0, cpu_pwr = '0, pci_bvalid, pci_blast;
   logic [31:0] cpu_addr = '0, pci_maddr = '0, cpu_paddr = '0, cpu_pdata = '0;
   logic [31:0] pci_baddr, pci_bdata, cfg_idsel;
   logic [63:0] cpu_wdata = '0, pci_mwdata = '0, rd_data;
   logic [5:0] pci_req = '0, pci_gnt, g;
   logic cfg_cycle = '0;
   logic [2:0] cfg_tgt = '0;
   logic [3:0][6:0] dimm_units = {7'h04, 7'h02, 7'h00, 7'h01};
   logic [3:0] dimm_dbl = 4'h4;
   logic [7:0] dram_row_n, dram_cas_n, row_acc;
   logic dram_we_n, dram_dq_oe;
   logic [11:0] dram_ma;
   logic [71:0] dram_dq_o, dram_dq_i, flip = '0;
   int err_count = 0, check_count = 0;

   hbd_ctl #(.QD(4), .NM(6)) dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .cpu_req(cpu_req), .cpu_we(cpu_we),
      .cpu_wc(cpu_wc), .cpu_smm(cpu_smm), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_ready(cpu_ready), .cpu_defer(cpu_defer), .cpu_rvalid(cpu_rvalid),
      .pci_mreq(pci_mreq), .pci_mwe(pci_mwe), .pci_maddr(pci_maddr), .pci_mwdata(pci_mwdata),
      .pci_mready(pci_mready), .pci_rvalid(pci_rvalid), .rd_data(rd_data), .cpu_pwr(cpu_pwr),
      .cpu_paddr(cpu_paddr), .cpu_pdata(cpu_pdata), .pci_bvalid(pci_bvalid),
      .pci_blast(pci_blast), .pci_baddr(pci_baddr), .pci_bdata(pci_bdata), .pci_req(pci_req),
      .pci_gnt(pci_gnt), .cfg_cycle(cfg_cycle), .cfg_tgt(cfg_tgt), .cfg_idsel(cfg_idsel),
      .dimm_units(dimm_units), .dimm_dbl(dimm_dbl), .dram_row_n(dram_row_n),
      .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n), .dram_ma(dram_ma),
      .dram_dq_o(dram_dq_o), .dram_dq_oe(dram_dq_oe), .dram_dq_i(dram_dq_i));
   hbd_dram_model dram (.core_clk(core_clk), .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n),
      .dram_ma(dram_ma), .dram_dq_o(dram_dq_o), .dram_dq_oe(dram_dq_oe), .flip(flip),
      .dram_dq_i(dram_dq_i));

   always #5 core_clk = ~core_clk;
   // Restarts on each request; sampled mid-cycle so it never races the edge
   always @(negedge core_clk) row_acc <= (cpu_req || pci_mreq) ? 8'hff : row_acc & dram_row_n;

   task automatic give_verdict();
      if (err_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat_i <= d;
      @(posedge core_clk);
      while (wb_ack !== 1'h1 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20) err_count++;
      q = wb_dat_o;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
      @(posedge core_clk);
   endtask
   // Memory request from processor (src 0) or PCI master (src 1)
   task automatic mem(input logic src, input logic we, input logic [31:0] a,
                      input logic [63:0] d);
      int n;
      n = 0;
      if (src) {pci_mreq, pci_mwe, pci_maddr, pci_mwdata} <= {1'h1, we, a, d};
      else {cpu_req, cpu_we, cpu_addr, cpu_wdata} <= {1'h1, we, a, d};
      @(posedge core_clk);
      while ((src ? pci_mready : cpu_ready) !== 1'h1 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      pci_mreq <= 1'h0;
      cpu_req <= 1'h0;
      @(posedge core_clk);
      while (!we && (src ? pci_rvalid : cpu_rvalid) !== 1'h1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 100) err_count++;
   endtask

   task automatic t_bounds();
      int acc;
      acc = 0;
      for (int b = 0; b < 8; b++) begin
         acc += dimm_units[b / 2] * ((b % 2 == 0) ? 1 : dimm_dbl[b / 2]);
         wb(1'h0, `HBD_A_DRB0 + 8'(4 * b), '0);
         chk(q, 64'(acc));
      end
      wb(1'h0, 8'hf0, '0);
      chk(q, '0);
   endtask
   task automatic t_idsel();
      int bits [7] = '{21, 23, 24, 25, 26, 29, 31};
      for (int i = 0; i < 7; i++) begin
         cfg_cycle <= 1'h1;
         cfg_tgt <= 3'(i);
         repeat (2) @(posedge core_clk);
         chk(cfg_idsel, 64'(32'h0000_0001 << bits[i]));
      end
      cfg_cycle <= 1'h0;
      repeat (2) @(posedge core_clk);
      chk(cfg_idsel, '0);
   endtask
   task automatic t_arb();
      pci_req <= 6'h05;
      repeat (3) @(posedge core_clk);
      g = pci_gnt;
      chk(64'(g === 6'h01 || g === 6'h04), 64'h1);
      pci_req <= 6'h05 & ~g;
      repeat (3) @(posedge core_clk);
      chk(pci_gnt, 6'h05 & ~g);
      pci_req <= '0;
   endtask
   task automatic t_burst();
      {cpu_pwr, cpu_paddr, cpu_pdata} <= {1'h1, 32'h0000_0100, 32'h0000_00aa};
      @(posedge core_clk);
      {cpu_paddr, cpu_pdata} <= {32'h0000_0104, 32'h0000_00bb};
      @(posedge core_clk);
      cpu_pwr <= 1'h0;
      @(posedge core_clk);
      chk({pci_bvalid, pci_blast, pci_baddr, pci_bdata},
          {2'h2, 32'h0000_0100, 32'h0000_00aa});
      @(posedge core_clk);
      chk({pci_bvalid, pci_blast, pci_baddr, pci_bdata},
          {2'h3, 32'h0000_0104, 32'h0000_00bb});
   endtask
   task automatic t_ecc();
      mem(1'h1, 1'h1, 32'h0000_0040, 64'h1234_5678_9abc_def0);
      flip <= 72'h20;
      wb(1'h1, `HBD_A_CTRL, 32'h0000_0002);
      mem(1'h1, 1'h0, 32'h0000_0040, '0);
      chk(rd_data, 64'h1234_5678_9abc_def0 ^ 64'h20);
      wb(1'h1, `HBD_A_CTRL, 32'h0000_0001);
      mem(1'h0, 1'h0, 32'h0000_0040, '0);
      chk(rd_data, 64'h1234_5678_9abc_def0);
      wb(1'h0, `HBD_A_STAT, '0);
      chk(q[0], 1'h1);
      flip <= 72'h30;
      mem(1'h0, 1'h0, 32'h0000_0040, '0);
      wb(1'h0, `HBD_A_STAT, '0);
      chk(q[1], 1'h1);
      flip <= '0;
      wb(1'h1, `HBD_A_STAT, 32'h0000_0007);
      wb(1'h1, `HBD_A_CTRL, '0);
   endtask
   task automatic t_strobe();
      logic [31:0] adr [3] = '{32'h0000_0000, 32'h0080_0000, 32'h0180_0000};
      logic [7:0] exp [3] = '{8'hfe, 8'hef, 8'hdf};
      for (int i = 0; i < 3; i++) begin
         mem(1'h0, 1'h0, adr[i], '0);
         chk(row_acc, exp[i]);
      end
   endtask
   task automatic t_refuse();
      wb(1'h1, `HBD_A_RGN0, 32'h0002_0000);
      mem(1'h0, 1'h0, 32'h0000_0000, '0);
      chk({row_acc, rd_data}, {8'hff, 64'h0});
      wb(1'h0, `HBD_A_STAT, '0);
      chk(q[2], 1'h1);
      wb(1'h1, `HBD_A_STAT, 32'h0000_0007);
      wb(1'h1, `HBD_A_RGN0, 32'h0003_0000);
      mem(1'h0, 1'h0, 32'h0480_0000, '0);
      chk({row_acc, rd_data}, {8'hff, 64'h0});
      wb(1'h1, `HBD_A_HOLE, 32'h0000_0103);
      mem(1'h0, 1'h0, 32'h0180_0000, '0);
      chk({row_acc, rd_data}, {8'hff, 64'h0});
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'h1;
      repeat (3) @(posedge core_clk);
      chk({dram_row_n, dram_cas_n}, 16'hffff);
      wb(1'h0, `HBD_A_CTRL, '0);
      chk(q, '0);
      t_bounds();
      t_idsel();
      t_arb();
      t_burst();
      t_ecc();
      t_strobe();
      t_refuse();
      give_verdict();
   end
   // Whole sequence needs a few hundred cycles
   initial begin
      #100000;
      err_count++;
      give_verdict();
   end
endmodule

// *** dv/hbd_dram_model.sv ***
`timescale 1ns/10ps
module hbd_dram_model (
   // Clock
   input wire logic core_clk,
   // DRAM pins from the controller
   input wire logic [7:0] dram_cas_n,
   input wire logic dram_we_n,
   input wire logic [11:0] dram_ma,
   input wire logic [71:0] dram_dq_o,
   input wire logic dram_dq_oe,
   // Error injection on read data only
   input wire logic [71:0] flip,
   // Read data to the controller
   output logic [71:0] dram_dq_i
);
   // Zeroed words are valid code words with zero check bits
   logic [71:0] mem [0:15] = '{default: '0};
   logic [3:0] col;
   logic hold;
   logic cas_on;
   logic [71:0] word;
   assign cas_on = (dram_cas_n != 8'hff);
   assign word = mem[cas_on ? dram_ma[3:0] : col] ^ flip;
   // Whole 72-bit lane stored, check bits included
   always @(posedge core_clk) begin
      if (cas_on) begin
         col <= dram_ma[3:0];
         if (!dram_we_n && dram_dq_oe) begin
            mem[dram_ma[3:0]] <= dram_dq_o;
         end
      end
      hold <= cas_on && dram_we_n;
   end
   // Data held one cycle past CAS for late sampling, inverted otherwise
   assign dram_dq_i = ((cas_on && dram_we_n) || hold) ? word : ~word;
endmodule

// *** src/hbd_ctl.sv ***
`timescale 1ns/10ps
`include "hbd_defs.svh"
// Contract
// R01: Correct any single-bit memory error; detect all double and some wider errors.
// R02: Error correction is off after reset until software enables it.
// R03: Memory path is one 72-bit lane: 64 data plus 8 check bits.
// R04: Four DIMM sockets, two row strobe lines per socket.
// R05: Single-banked DIMM uses one row strobe for both halves.
// R06: Double-banked DIMM uses two strobes, each selecting its own bank.
// R07: Total memory 8MB to 1GB from up to four DIMMs.
// R08: Any socket order, mixed sizes; auto-size and report row boundaries.
// R09: Memory flat from zero to top, gaps only at configured holes.
// R10: Regions from configuration registers with enforced read/write attributes.
// R11: Timing for both fast page mode and extended data out DRAM.
// R12: Only memory data is protected; no bus code, no parity.
// R13: Processor side uses 32-bit addresses and a four-deep request queue.
// R14: Deferred processor transactions and write-combining memory writes supported.
// R15: Buffer memory writes; combine processor-to-PCI writes into bursts.
// R16: Bridge arbitrates PCI and grants every requesting master.
// R17: System management mode transactions are supported.
// R18: Configuration target select uses one AD bit per target.
// R19: Clock source gives PCI clock at half processor clock, processor leading. The design has no clock source; everything runs on core_clk.
// R20: Eight check bits per word on write; check and correct on read.
module hbd_ctl
   import hbd_pkg::*;
#(
   parameter int QD = `HBD_QDEPTH,
   parameter int NM = `HBD_NMAST
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Wishbone register slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack,
   // Processor memory requests
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic cpu_wc,
   input wire logic cpu_smm,
   input wire logic [31:0] cpu_addr,
   input wire logic [63:0] cpu_wdata,
   output logic cpu_ready,
   output logic cpu_defer,
   output logic cpu_rvalid,
   // PCI master memory requests
   input wire logic pci_mreq,
   input wire logic pci_mwe,
   input wire logic [31:0] pci_maddr,
   input wire logic [63:0] pci_mwdata,
   output logic pci_mready,
   output logic pci_rvalid,
   output logic [63:0] rd_data,
   // Processor to PCI writes
   input wire logic cpu_pwr,
   input wire logic [31:0] cpu_paddr,
   input wire logic [31:0] cpu_pdata,
   output logic pci_bvalid,
   output logic pci_blast,
   output logic [31:0] pci_baddr,
   output logic [31:0] pci_bdata,
   // PCI arbitration and configuration select
   input wire logic [NM-1:0] pci_req,
   output logic [NM-1:0] pci_gnt,
   input wire logic cfg_cycle,
   input wire logic [2:0] cfg_tgt,
   output logic [31:0] cfg_idsel,
   // DIMM size straps, 8MB units per bank
   input wire logic [3:0][6:0] dimm_units,
   input wire logic [3:0] dimm_dbl,
   // DRAM pins
   output logic [7:0] dram_row_n,
   output logic [7:0] dram_cas_n,
   output logic dram_we_n,
   output logic [11:0] dram_ma,
   output logic [71:0] dram_dq_o,
   output logic dram_dq_oe,
   input wire logic [71:0] dram_dq_i
);
   localparam int PW = $clog2(QD);
   localparam int TRCD = `HBD_CYC(`HBD_TRCD_NS);
   localparam int TCAS = `HBD_CYC(`HBD_TCAS_NS);
   localparam int TRP = `HBD_CYC(`HBD_TRP_NS);

   // Hamming over positions 1..71 plus overall parity in bit 7
   function automatic logic [7:0] ecc_gen(input logic [63:0] d);
      logic [7:0] c;
      int k;
      c = 8'h00;
      k = 0;
      for (int p = 1; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            for (int i = 0; i < 7; i++) begin
               if (p[i]) c[i] = c[i] ^ d[k];
            end
            k++;
         end
      end
      c[7] = ^{d, c[6:0]};
      return c;
   endfunction

   function automatic logic [63:0] ecc_fix(input logic [63:0] d, input logic [6:0] s);
      logic [63:0] o;
      int k;
      o = d;
      k = 0;
      for (int p = 1; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (7'(p) == s) o[k] = ~o[k];
            k++;
         end
      end
      return o;
   endfunction

   function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
      end
      return o;
   endfunction

   function automatic logic [31:0] idsel(input logic [2:0] t);
      unique case (t)
         TG_NIC: idsel = 32'h1 << `HBD_IDSEL_NIC;
         TG_SLOT1: idsel = 32'h1 << `HBD_IDSEL_SLOT1;
         TG_SCSI: idsel = 32'h1 << `HBD_IDSEL_SCSI;
         TG_SLOT2: idsel = 32'h1 << `HBD_IDSEL_SLOT2;
         TG_SLOT3: idsel = 32'h1 << `HBD_IDSEL_SLOT3;
         TG_SOUTH: idsel = 32'h1 << `HBD_IDSEL_SOUTH;
         TG_VIDEO: idsel = 32'h1 << `HBD_IDSEL_VIDEO;
         default: idsel = 32'h0000_0000;
      endcase
   endfunction

   logic [1:0] ctrl_reg, ctrl_next;
   logic [2:0] stat_reg, stat_next;
   logic [31:0] hole_reg, hole_next, eadr_reg, eadr_next;
   logic [31:0] rgn_reg [4], rgn_next [4];
   logic [7:0] drb_reg [8], drb_next [8];
   logic sized_reg, ack_reg;
   logic [31:0] dat_reg, dat_next;
   hbd_req_t q_reg [QD], q_next [QD];
   logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [PW:0] cnt_reg, cnt_next;
   hbd_state_t st_reg, st_next;
   logic [3:0] tmr_reg, tmr_next;
   logic [2:0] row_reg, row_next;
   logic done_reg, dsrc_reg, dwe_reg, done_next;
   logic [63:0] rdat_reg, rdat_next;
   logic [7:0] row_n_next, cas_n_next;
   logic we_n_next, oe_next;
   logic [11:0] ma_next;
   logic [NM-1:0] gnt_next;
   logic [$clog2(NM)-1:0] lst_reg, lst_next;
   logic [31:0] idsel_next;
   logic pv_reg, pv_next, bv_next, bl_next;
   logic [31:0] pa_reg, pa_next, pd_reg, pd_next, ba_next, bd_next;
   hbd_req_t hd;
   logic [6:0] unit;
   logic in_hole, perm, ok, space, merge, cap, wr, sbe_ev, dbe_ev, vio_ev;
   logic [7:0] syn;
   logic [2:0] row_sel;

   assign wr = wb_cyc && wb_stb && wb_we && ack_reg;
   assign wb_ack = ack_reg;
   assign wb_dat_o = dat_reg;

   // Register file; status bits are write-one-to-clear, new events win
   always_comb begin
      logic [7:0] acc;
      acc = 8'h00;
      ctrl_next = ctrl_reg;
      hole_next = hole_reg;
      eadr_next = eadr_reg;
      rgn_next = rgn_reg;
      drb_next = drb_reg;
      stat_next = stat_reg;
      dat_next = 32'h0000_0000;
      if (wr && wb_adr == `HBD_A_CTRL) ctrl_next = 2'(wmask(32'(ctrl_reg), wb_dat_i, wb_sel));
      if (wr && wb_adr == `HBD_A_HOLE) hole_next = wmask(hole_reg, wb_dat_i, wb_sel);
      if (wr && wb_adr == `HBD_A_STAT) begin
         stat_next = stat_reg & ~3'(wmask(32'h0, wb_dat_i, wb_sel));
      end
      for (int r = 0; r < 4; r++) begin
         if (wr && wb_adr == `HBD_A_RGN0 + 8'(4 * r)) begin
            rgn_next[r] = wmask(rgn_reg[r], wb_dat_i, wb_sel);
         end
      end
      stat_next[`HBD_B_SBE] = stat_next[`HBD_B_SBE] | sbe_ev;
      stat_next[`HBD_B_DBE] = stat_next[`HBD_B_DBE] | dbe_ev;
      stat_next[`HBD_B_VIO] = stat_next[`HBD_B_VIO] | vio_ev;
      if (sbe_ev || dbe_ev) eadr_next = hd.addr;
      // Sizing from straps once after reset, banks in socket order
      for (int s = 0; s < 4; s++) begin
         for (int h = 0; h < 2; h++) begin
            if (h == 0 || dimm_dbl[s]) acc = acc + 8'(dimm_units[s]); // R05 R06 R07
            if (!sized_reg) drb_next[2*s+h] = acc; // R08
         end
      end
      if (wb_adr == `HBD_A_CTRL) dat_next = 32'(ctrl_reg);
      else if (wb_adr == `HBD_A_STAT) dat_next = 32'(stat_reg);
      else if (wb_adr == `HBD_A_HOLE) dat_next = hole_reg;
      else if (wb_adr == `HBD_A_EADR) dat_next = eadr_reg;
      else if (wb_adr[7:4] == 4'h1 && wb_adr[1:0] == 2'h0) dat_next = rgn_reg[wb_adr[3:2]];
      else if (wb_adr[7:5] == 3'h1 && wb_adr[1:0] == 2'h0) dat_next = 32'(drb_reg[wb_adr[4:2]]);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `HBD_CTRL_RST; // R02
         stat_reg <= 3'h0;
         hole_reg <= 32'h0000_0000;
         eadr_reg <= 32'h0000_0000;
         // Idle regions grant full access, else unit 0 would be refused
         rgn_reg <= '{default: `HBD_RGN_RST};
         drb_reg <= '{default: 8'h00};
         sized_reg <= 1'b0;
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         stat_reg <= stat_next;
         hole_reg <= hole_next;
         eadr_reg <= eadr_next;
         rgn_reg <= rgn_next;
         drb_reg <= drb_next;
         sized_reg <= 1'b1;
         ack_reg <= wb_cyc && wb_stb && !ack_reg;
         dat_reg <= dat_next;
      end
   end

   // Decode of the queue head: flat map, hole, regions
   always_comb begin
      hd = q_reg[rp_reg];
      unit = hd.addr[`HBD_UNIT_LSB +: 7];
      in_hole = hole_reg[15:8] != 8'h00 && 9'(unit) >= {1'b0, hole_reg[7:0]}
                && 9'(unit) < {1'b0, hole_reg[7:0]} + {1'b0, hole_reg[15:8]}; // R09
      perm = 1'b1;
      for (int r = 0; r < 4; r++) begin
         if ({1'b0, unit} >= rgn_reg[r][7:0] && {1'b0, unit} <= rgn_reg[r][15:8]) begin
            perm = perm && (hd.we ? rgn_reg[r][`HBD_B_WR] : rgn_reg[r][`HBD_B_RD]); // R10
            perm = perm && (!rgn_reg[r][`HBD_B_SMM] || hd.system_management_mode); // R17
         end
      end
      row_sel = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if ({1'b0, unit} < drb_reg[i]) row_sel = 3'(i); // R04
      end
      ok = hd.addr[31:30] == 2'b00 && {1'b0, unit} < drb_reg[7] && !in_hole && perm; // R09
   end

   // Request queue with write combining on the tail entry
   assign space = cnt_reg < (PW+1)'(QD);
   assign merge = cpu_we && cpu_wc && cnt_reg >= (PW+1)'(2) && q_reg[wp_reg - 1'b1].we
                  && !q_reg[wp_reg - 1'b1].src && q_reg[wp_reg - 1'b1].addr == cpu_addr;
   assign pci_mready = space;
   assign cpu_ready = !pci_mreq && (space || merge); // R13
   assign cpu_defer = cpu_req && !cpu_ready; // R14

   always_comb begin
      q_next = q_reg;
      wp_next = wp_reg;
      rp_next = rp_reg;
      cnt_next = cnt_reg;
      if (pci_mreq && space) begin
         q_next[wp_reg] = '{1'b1, pci_mwe, 1'b0, pci_maddr, pci_mwdata}; // R15
         wp_next = wp_reg + 1'b1;
         cnt_next = cnt_next + 1'b1;
      end else if (cpu_req && merge) begin
         q_next[wp_reg - 1'b1].wdata = cpu_wdata; // R14
      end else if (cpu_req && space) begin
         q_next[wp_reg] = '{1'b0, cpu_we, cpu_smm, cpu_addr, cpu_wdata}; // R15 R17
         wp_next = wp_reg + 1'b1;
         cnt_next = cnt_next + 1'b1;
      end
      if (done_next) begin
         rp_next = rp_reg + 1'b1;
         cnt_next = cnt_next - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q_reg <= '{default: '0};
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         q_reg <= q_next;
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   // DRAM sequencer; EDO data is taken after CAS rises, FPM while CAS is low
   assign cap = !hd.we && ((st_reg == ST_CAS && tmr_reg == 4'h0 && !ctrl_reg[`HBD_B_EDO])
                || (st_reg == ST_PRE && tmr_reg == 4'(TRP - 1) && ctrl_reg[`HBD_B_EDO])); // R11
   // Overall parity over the whole received word, not the recomputed bits
   assign syn = {^dram_dq_i, 7'(ecc_gen(dram_dq_i[63:0]) ^ dram_dq_i[71:64])}; // R20
   assign sbe_ev = cap && ctrl_reg[`HBD_B_ECC] && syn[7]; // R01
   assign dbe_ev = cap && ctrl_reg[`HBD_B_ECC] && !syn[7] && syn[6:0] != 7'h00; // R01
   assign vio_ev = st_reg == ST_IDLE && cnt_reg != '0 && !ok;

   always_comb begin
      st_next = st_reg;
      tmr_next = tmr_reg;
      row_next = row_reg;
      done_next = 1'b0;
      rdat_next = rdat_reg;
      if (tmr_reg != 4'h0) tmr_next = tmr_reg - 1'b1;
      if (cap) begin
         rdat_next = ctrl_reg[`HBD_B_ECC] && sbe_ev ? ecc_fix(dram_dq_i[63:0], syn[6:0])
                     : dram_dq_i[63:0]; // R01 R02 R12
      end
      unique case (st_reg)
         ST_IDLE: begin
            if (cnt_reg != '0 && ok) begin
               st_next = ST_RAS;
               tmr_next = 4'(TRCD - 1);
               row_next = row_sel;
            end else if (cnt_reg != '0) begin
               done_next = 1'b1; // R10
               rdat_next = 64'h0000_0000_0000_0000;
            end
         end
         ST_RAS: begin
            if (tmr_reg == 4'h0) begin
               st_next = ST_CAS;
               tmr_next = 4'(TCAS - 1);
            end
         end
         ST_CAS: begin
            if (tmr_reg == 4'h0) begin
               st_next = ST_PRE;
               tmr_next = 4'(TRP - 1);
            end
         end
         ST_PRE: begin
            if (tmr_reg == 4'h0) begin
               st_next = ST_IDLE;
               done_next = 1'b1;
            end
         end
         default: st_next = ST_IDLE;
      endcase
      row_n_next = (st_next == ST_RAS || st_next == ST_CAS) ? ~(8'h01 << row_next) : 8'hFF;
      cas_n_next = st_next == ST_CAS ? 8'h00 : 8'hFF;
      we_n_next = !(hd.we && st_next != ST_IDLE && st_next != ST_PRE);
      oe_next = !we_n_next;
      ma_next = st_next == ST_CAS ? {4'h0, hd.addr[10:3]} : hd.addr[22:11];
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= ST_IDLE;
         tmr_reg <= 4'h0;
         row_reg <= 3'h0;
         done_reg <= 1'b0;
         dsrc_reg <= 1'b0;
         dwe_reg <= 1'b0;
         rdat_reg <= 64'h0000_0000_0000_0000;
         dram_row_n <= 8'hFF;
         dram_cas_n <= 8'hFF;
         dram_we_n <= 1'b1;
         dram_dq_oe <= 1'b0;
         dram_ma <= 12'h000;
         dram_dq_o <= '0;
      end else begin
         st_reg <= st_next;
         tmr_reg <= tmr_next;
         row_reg <= row_next;
         done_reg <= done_next;
         dsrc_reg <= hd.src;
         dwe_reg <= hd.we;
         rdat_reg <= rdat_next;
         dram_row_n <= row_n_next;
         dram_cas_n <= cas_n_next;
         dram_we_n <= we_n_next;
         dram_dq_oe <= oe_next;
         dram_ma <= ma_next;
         dram_dq_o <= {ecc_gen(hd.wdata), hd.wdata}; // R03 R20
      end
   end

   assign rd_data = rdat_reg;
   assign cpu_rvalid = done_reg && !dsrc_reg && !dwe_reg;
   assign pci_rvalid = done_reg && dsrc_reg && !dwe_reg;

   // Round-robin PCI arbiter, owner keeps the bus while requesting
   always_comb begin
      gnt_next = pci_gnt;
      lst_next = lst_reg;
      if (!(|(pci_req & pci_gnt))) begin
         gnt_next = '0;
         for (int i = NM; i > 0; i--) begin
            if (pci_req[(int'(lst_reg) + i) % NM]) begin
               gnt_next = NM'(1) << ((int'(lst_reg) + i) % NM); // R16
               lst_next = ($clog2(NM))'((int'(lst_reg) + i) % NM);
            end
         end
      end
      idsel_next = cfg_cycle ? idsel(cfg_tgt) : 32'h0000_0000; // R18
   end

   // Back-to-back processor-to-PCI writes to addresses rising by 4 leave as one burst
   always_comb begin
      pv_next = pv_reg;
      pa_next = pa_reg;
      pd_next = pd_reg;
      bv_next = pv_reg;
      bl_next = 1'b1;
      ba_next = pa_reg;
      bd_next = pd_reg;
      if (cpu_pwr) begin
         bl_next = cpu_paddr != pa_reg + 32'h0000_0004; // R15
         pv_next = 1'b1;
         pa_next = cpu_paddr;
         pd_next = cpu_pdata;
      end else begin
         pv_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pci_gnt <= '0;
         lst_reg <= '0;
         cfg_idsel <= 32'h0000_0000;
         pv_reg <= 1'b0;
         pa_reg <= 32'h0000_0000;
         pd_reg <= 32'h0000_0000;
         pci_bvalid <= 1'b0;
         pci_blast <= 1'b0;
         pci_baddr <= 32'h0000_0000;
         pci_bdata <= 32'h0000_0000;
      end else begin
         pci_gnt <= gnt_next;
         lst_reg <= lst_next;
         cfg_idsel <= idsel_next;
         pv_reg <= pv_next;
         pa_reg <= pa_next;
         pd_reg <= pd_next;
         pci_bvalid <= bv_next;
         pci_blast <= bl_next;
         pci_baddr <= ba_next;
         pci_bdata <= bd_next;
      end
   end

   chk_ecc_dbl_flag: assert property (@(posedge core_clk) disable iff (!rstn) // R01
      dbe_ev |=> stat_reg[`HBD_B_DBE]) else $error("double error not flagged");
   chk_ecc_off_raw: assert property (@(posedge core_clk) disable iff (!rstn) // R02
      cap && !ctrl_reg[`HBD_B_ECC] |=> rd_data == $past(dram_dq_i[63:0]))
      else $error("data altered while correction off");
   chk_row_onehot: assert property (@(posedge core_clk) disable iff (!rstn) // R04
      $onehot0(~dram_row_n)) else $error("more than one row strobe");
   chk_cas_in_row: assert property (@(posedge core_clk) disable iff (!rstn) // R11
      !dram_cas_n[0] |-> dram_row_n != 8'hFF) else $error("column strobe without row");
   chk_queue_bound: assert property (@(posedge core_clk) disable iff (!rstn) // R13
      cnt_reg <= (PW+1)'(QD) && !(cnt_reg == (PW+1)'(QD) && !merge && cpu_ready))
      else $error("queue overrun");
   chk_arb_grant: assert property (@(posedge core_clk) disable iff (!rstn) // R16
      |pci_req && !(|(pci_req & pci_gnt)) |=> $onehot(pci_gnt))
      else $error("requester not granted");
   chk_idsel_bit: assert property (@(posedge core_clk) disable iff (!rstn) // R18
      cfg_cycle && cfg_tgt == TG_SOUTH |=> cfg_idsel == 32'h2000_0000)
      else $error("wrong config select");
   chk_vio_blocked: assert property (@(posedge core_clk) disable iff (!rstn) // R10
      vio_ev |=> dram_row_n == 8'hFF && done_reg) else $error("refused access reached DRAM");
   chk_burst_cont: assert property (@(posedge core_clk) disable iff (!rstn) // R15
      pci_bvalid && !pci_blast |=> pci_bvalid && pci_baddr == $past(pci_baddr) + 32'h0000_0004)
      else $error("burst broken");
endmodule

// *** src/hbd_defs.svh ***
`ifndef HBD_DEFS_SVH
`define HBD_DEFS_SVH
`define HBD_A_CTRL 8'h00
`define HBD_A_STAT 8'h04
`define HBD_A_HOLE 8'h08
`define HBD_A_EADR 8'h0C
`define HBD_A_RGN0 8'h10
`define HBD_A_DRB0 8'h20
`define HBD_B_ECC 0
`define HBD_B_EDO 1
`define HBD_B_SBE 0
`define HBD_B_DBE 1
`define HBD_B_VIO 2
`define HBD_B_RD 16
`define HBD_B_WR 17
`define HBD_B_SMM 18
`define HBD_CTRL_RST 2'h0
`define HBD_RGN_RST 32'h0003_0000
`define HBD_UNIT_LSB 23
`define HBD_QDEPTH 4
`define HBD_NMAST 6
`define HBD_CLK_NS 10
`define HBD_TRCD_NS 30
`define HBD_TCAS_NS 20
`define HBD_TRP_NS 30
`define HBD_CYC(ns) (((ns) + `HBD_CLK_NS - 1) / `HBD_CLK_NS)
`define HBD_IDSEL_NIC 21
`define HBD_IDSEL_SLOT1 23
`define HBD_IDSEL_SCSI 24
`define HBD_IDSEL_SLOT2 25
`define HBD_IDSEL_SLOT3 26
`define HBD_IDSEL_SOUTH 29
`define HBD_IDSEL_VIDEO 31
`endif

// *** src/hbd_pkg.sv ***
package hbd_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RAS = 4'h2,
      ST_CAS = 4'h4,
      ST_PRE = 4'h8
   } hbd_state_t;
   typedef enum logic [2:0] {
      TG_NIC, TG_SLOT1, TG_SCSI, TG_SLOT2, TG_SLOT3, TG_SOUTH, TG_VIDEO
   } hbd_tgt_t;
   typedef struct packed {
      logic src;
      logic we;
      logic system_management_mode;
      logic [31:0] addr;
      logic [63:0] wdata;
   } hbd_req_t;
endpackage
